/* rtl/aipbch_regs.svh */
// Constants for the asynchronous phase protection code
`ifndef AIPBCH_REGS_SVH
`define AIPBCH_REGS_SVH
`define AIPBCH_CW_W        21
`define AIPBCH_INFO_W      15
`define AIPBCH_CHK_W       6
`define AIPBCH_SEQ_LO      13
`define AIPBCH_SEQ_HI      14
`define AIPBCH_CHK_LO      15
`define AIPBCH_LANE_CHK    10
`define AIPBCH_EN_VALID    1
`define AIPBCH_DIS_FAIL    4
`define AIPBCH_SEQ_ZERO    2'h0
`define AIPBCH_SEQ_ONE     2'h1
`define AIPBCH_RSVD_ZERO   3'h0
`define AIPBCH_MASK_C0     15'h2CEF
`define AIPBCH_MASK_C1     15'h59DE
`define AIPBCH_MASK_C2     15'h1F53
`define AIPBCH_MASK_C3     15'h3EA6
`define AIPBCH_MASK_C4     15'h7D4C
`define AIPBCH_MASK_C5     15'h5677
`endif

/* rtl/aipbch_pkg.sv */
// Types and check bit function for the asynchronous phase protection code
`include "aipbch_regs.svh"
package aipbch_pkg;
    typedef logic [`AIPBCH_INFO_W-1:0] aipbch_info_t;
    typedef logic [`AIPBCH_CHK_W-1:0]  aipbch_chk_t;

    typedef enum logic [1:0] {
        AIPBCH_NEXUS_OFF = 2'b01,
        AIPBCH_NEXUS_ON  = 2'b10
    } aipbch_nexus_t;

    // Parallel check bits from the fifteen information positions
    function automatic aipbch_chk_t aipbch_check(input aipbch_info_t info);
        aipbch_chk_t c;
        c[0] = ^(info & `AIPBCH_MASK_C0);
        c[1] = ^(info & `AIPBCH_MASK_C1);
        c[2] = ^(info & `AIPBCH_MASK_C2);
        c[3] = ^(info & `AIPBCH_MASK_C3);
        c[4] = ^(info & `AIPBCH_MASK_C4);
        c[5] = ^(info & `AIPBCH_MASK_C5);
        return c;
    endfunction

    // Information positions: byte, lines 8 and 9, zeros, sequence id
    function automatic aipbch_info_t aipbch_pack(input logic [7:0] data,
                                                 input logic [1:0] up, input logic [1:0] seq);
        return {seq, `AIPBCH_RSVD_ZERO, up, data};
    endfunction
endpackage

/* rtl/aipbch_link_if.sv */
// Wide bus lanes shared by the two ends
`timescale 1ns/100ps
interface aipbch_link_if;
    logic [15:0] tx_db;
    logic [1:0]  tx_par;
    logic        tx_strobe;
    logic        tx_phase_change;
    logic        tx_retry;
    logic [15:0] rx_db;
    logic [1:0]  rx_par;
    logic        rx_strobe;
    logic        rx_phase_change;
    logic        rx_retry;

    modport dev_end (
        output tx_db, tx_par, tx_strobe, tx_phase_change, tx_retry,
        input  rx_db, rx_par, rx_strobe, rx_phase_change, rx_retry
    );
    modport peer_end (
        input  tx_db, tx_par, tx_strobe, tx_phase_change, tx_retry,
        output rx_db, rx_par, rx_strobe, rx_phase_change, rx_retry
    );
endinterface

/* rtl/aipbch_peer.sv */
// Far end: protected transmitter and code checker for the link
`timescale 1ns/100ps
module aipbch_peer
    import aipbch_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           reset,
    aipbch_link_if.peer_end     link,
    input  wire logic           send_valid,
    input  wire logic [7:0]     send_data,
    input  wire logic           send_phase_change,
    input  wire logic           send_retry,
    output logic                recv_valid,
    output logic [7:0]          recv_data,
    output logic                recv_err
);
`include "aipbch_regs.svh"
    logic [1:0]  tx_seq, next_tx_seq, rx_seq, next_rx_seq;
    logic [15:0] db, next_db;
    logic [1:0]  par, next_par;
    logic        stb, next_stb, pc, next_pc, rt, next_rt;
    logic        next_recv_valid, next_recv_err;
    logic [7:0]  next_recv_data;
    aipbch_info_t tinfo, rinfo;

    always_comb begin
        next_tx_seq = tx_seq;
        if (send_phase_change || send_retry) begin
            next_tx_seq = `AIPBCH_SEQ_ZERO;
        end
        tinfo = aipbch_pack(send_data, 2'h0, next_tx_seq);
        if (send_valid) begin
            next_tx_seq = next_tx_seq + `AIPBCH_SEQ_ONE;
        end
        next_db  = db;
        next_par = par;
        next_stb = send_valid;
        next_pc  = send_phase_change;
        next_rt  = send_retry;
        if (send_valid) begin
            next_db  = {aipbch_check(tinfo), 2'b00, send_data};
            next_par = {~^next_db[15:8], ~^send_data};
        end
        // Retry restarts the run at this end too
        next_rx_seq = (link.tx_phase_change || link.tx_retry) ? `AIPBCH_SEQ_ZERO : rx_seq;
        rinfo = aipbch_pack(link.tx_db[7:0], 2'h0, next_rx_seq);
        next_recv_valid = link.tx_strobe;
        next_recv_data  = recv_data;
        next_recv_err   = 1'b0;
        if (link.tx_strobe) begin
            next_rx_seq = next_rx_seq + `AIPBCH_SEQ_ONE;
            next_recv_data = link.tx_db[7:0];
            next_recv_err = (aipbch_check(rinfo) != link.tx_db[15:10]) ||
                            (^{link.tx_par[0], link.tx_db[7:0]} != 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_seq <= '0;
            rx_seq <= '0;
            db <= '0;
            par <= '0;
            stb <= 1'b0;
            pc <= 1'b0;
            rt <= 1'b0;
            recv_valid <= 1'b0;
            recv_data <= '0;
            recv_err <= 1'b0;
        end else begin
            tx_seq <= next_tx_seq;
            rx_seq <= next_rx_seq;
            db <= next_db;
            par <= next_par;
            stb <= next_stb;
            pc <= next_pc;
            rt <= next_rt;
            recv_valid <= next_recv_valid;
            recv_data <= next_recv_data;
            recv_err <= next_recv_err;
        end
    end

    assign link.rx_db = db;
    assign link.rx_par = par;
    assign link.rx_strobe = stb;
    assign link.rx_phase_change = pc;
    assign link.rx_retry = rt;
endmodule

/* rtl/aipbch_dev.sv */
// Device end: protection code generation, checking and nexus enables
`timescale 1ns/100ps
`include "aipbch_regs.svh"
module aipbch_dev
    import aipbch_pkg::*;
#(
    parameter int NEXUS_N    = 16,
    parameter int NEXUS_W    = 4,
    parameter int EN_VALID   = `AIPBCH_EN_VALID,
    parameter int DIS_FAIL   = `AIPBCH_DIS_FAIL
)(
    input  wire logic               clk,
    input  wire logic               reset,
    aipbch_link_if.dev_end          link,
    input  wire logic               wide_ok,
    input  wire logic               clear_all,
    input  wire logic               iu_mode,
    input  wire logic [NEXUS_W-1:0] nexus,
    input  wire logic               send_valid,
    input  wire logic [7:0]         send_data,
    input  wire logic               send_phase_change,
    input  wire logic               send_retry,
    output logic                    recv_valid,
    output logic [7:0]              recv_data,
    output logic                    recv_invalid,
    output logic                    code_err,
    output logic [NEXUS_N-1:0]      nexus_enabled
);
    localparam int CNT_W = 4;
    logic [1:0]  tx_seq, next_tx_seq, rx_seq, next_rx_seq;
    logic [15:0] db, next_db;
    logic [1:0]  par, next_par;
    logic        stb, next_stb, pc, next_pc, rt, next_rt;
    logic        next_recv_valid, next_recv_invalid, next_code_err;
    logic [7:0]  next_recv_data;
    aipbch_nexus_t nst [NEXUS_N];
    aipbch_nexus_t next_nst [NEXUS_N];
    logic [CNT_W-1:0] good_cnt, next_good_cnt, bad_cnt, next_bad_cnt;
    aipbch_info_t tinfo, rinfo;
    logic        par_lo_ok, par_hi_ok, upper_quiet, chk_ok, active;

    // ****************
    // Transmit side
    // ****************
    always_comb begin
        next_tx_seq = tx_seq;
        if (send_phase_change || send_retry) begin
            next_tx_seq = `AIPBCH_SEQ_ZERO;
        end
        // Restarted id already covers the word that opens a run
        tinfo = aipbch_pack(send_data, 2'h0, next_tx_seq);
        if (send_valid) begin
            next_tx_seq = next_tx_seq + `AIPBCH_SEQ_ONE;
        end
        next_db  = db;
        next_par = par;
        next_stb = send_valid;
        next_pc  = send_phase_change;
        next_rt  = send_retry;
        if (send_valid) begin
            next_db[7:0]  = send_data;
            next_db[9:8]  = 2'b00;
            next_db[15:10] = wide_ok ? aipbch_check(tinfo) : 6'h00;
            next_par = {~^next_db[15:8], ~^send_data};
        end
    end

    // ****************
    // Receive side and nexus enables
    // ****************
    always_comb begin
        next_rx_seq = (link.rx_phase_change || link.rx_retry) ? `AIPBCH_SEQ_ZERO : rx_seq;
        // Expected id of this word, restarted when it opens a run
        rinfo = aipbch_pack(link.rx_db[7:0], 2'h0, next_rx_seq);
        par_lo_ok = ^{link.rx_par[0], link.rx_db[7:0]};
        par_hi_ok = ^{link.rx_par[1], link.rx_db[15:8]};
        upper_quiet = (link.rx_db[15:8] == 8'h00) && !link.rx_par[1];
        chk_ok = (aipbch_check(rinfo) == link.rx_db[15:10]) && par_hi_ok;
        active = link.rx_strobe && wide_ok && !iu_mode;
        next_recv_valid = link.rx_strobe;
        next_recv_data = recv_data;
        next_recv_invalid = 1'b0;
        next_code_err = 1'b0;
        next_good_cnt = good_cnt;
        next_bad_cnt = bad_cnt;
        for (int i = 0; i < NEXUS_N; i++) begin
            next_nst[i] = nst[i];
        end
        if (link.rx_strobe) begin
            next_rx_seq = next_rx_seq + `AIPBCH_SEQ_ONE;
            next_recv_data = link.rx_db[7:0];
            next_recv_invalid = !par_lo_ok;
        end
        if (active && par_lo_ok) begin
            if (nst[nexus] == AIPBCH_NEXUS_ON) begin
                if (!chk_ok) begin
                    next_code_err = 1'b1;
                    next_recv_invalid = 1'b1;
                end
                if (chk_ok) begin
                    next_bad_cnt = '0;
                end else if (upper_quiet || bad_cnt + 1'b1 >= CNT_W'(DIS_FAIL)) begin
                    next_nst[nexus] = AIPBCH_NEXUS_OFF;
                    next_bad_cnt = '0;
                end else begin
                    next_bad_cnt = bad_cnt + 1'b1;
                end
            end else begin
                if (!chk_ok) begin
                    next_good_cnt = '0;
                end else if (good_cnt + 1'b1 >= CNT_W'(EN_VALID)) begin
                    next_nst[nexus] = AIPBCH_NEXUS_ON;
                    next_good_cnt = '0;
                end else begin
                    next_good_cnt = good_cnt + 1'b1;
                end
            end
        end
        if (clear_all) begin
            for (int i = 0; i < NEXUS_N; i++) begin
                next_nst[i] = AIPBCH_NEXUS_OFF;
            end
            next_good_cnt = '0;
            next_bad_cnt = '0;
        end
    end

    // ****************
    // State registers
    // ****************
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_seq <= '0;
            rx_seq <= '0;
            db <= '0;
            par <= '0;
            stb <= 1'b0;
            pc <= 1'b0;
            rt <= 1'b0;
            recv_valid <= 1'b0;
            recv_data <= '0;
            recv_invalid <= 1'b0;
            code_err <= 1'b0;
            good_cnt <= '0;
            bad_cnt <= '0;
            for (int i = 0; i < NEXUS_N; i++) begin
                nst[i] <= AIPBCH_NEXUS_OFF;
            end
        end else begin
            tx_seq <= next_tx_seq;
            rx_seq <= next_rx_seq;
            db <= next_db;
            par <= next_par;
            stb <= next_stb;
            pc <= next_pc;
            rt <= next_rt;
            recv_valid <= next_recv_valid;
            recv_data <= next_recv_data;
            recv_invalid <= next_recv_invalid;
            code_err <= next_code_err;
            good_cnt <= next_good_cnt;
            bad_cnt <= next_bad_cnt;
            for (int i = 0; i < NEXUS_N; i++) begin
                nst[i] <= next_nst[i];
            end
        end
    end

    // ****************
    // Nexus enable flags
    // ****************
    generate
        for (genvar g = 0; g < NEXUS_N; g++) begin : g_en
            assign nexus_enabled[g] = (nst[g] == AIPBCH_NEXUS_ON);
        end
    endgenerate

    // ****************
    // Lane outputs
    // ****************
    assign link.tx_db = db;
    assign link.tx_par = par;
    assign link.tx_strobe = stb;
    assign link.tx_phase_change = pc;
    assign link.tx_retry = rt;
endmodule

/* dv/aipbch_ref.svh */
// Reference check bits worked out by serial division
`ifndef AIPBCH_REF_SVH
`define AIPBCH_REF_SVH
function automatic logic [5:0] aipbch_ref_chk(input logic [7:0] d, input logic [1:0] s);
    logic [14:0] w;
    logic [5:0]  r;
    w = {s, 5'h00, d};
    r = 6'h00;
    for (int i = 14; i >= 0; i--) begin
        r = {r[4:0], 1'h0} ^ ((w[i] ^ r[5]) ? 6'h25 : 6'h00);
    end
    return r;
endfunction
`endif

/* dv/aipbch_chk.sv */
// Checker of wire format, parity and sequence check bits on the link
`timescale 1ns/100ps
`include "aipbch_ref.svh"
module aipbch_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [15:0] tx_db,
    input wire logic [1:0]  tx_par,
    input wire logic        tx_strobe,
    input wire logic        tx_phase_change,
    input wire logic        tx_retry,
    input wire logic [15:0] rx_db,
    input wire logic [1:0]  rx_par,
    input wire logic        rx_strobe,
    input wire logic        rx_phase_change,
    input wire logic        rx_retry
);
    logic [1:0] tseq, next_tseq, texp;
    logic [1:0] rseq, next_rseq, rexp;
    // Expected sequence id of the word on each lane
    always_comb begin
        texp = (tx_phase_change | tx_retry) ? 2'h0 : tseq;
        rexp = (rx_phase_change | rx_retry) ? 2'h0 : rseq;
        next_tseq = tx_strobe ? texp + 2'h1 : texp;
        next_rseq = rx_strobe ? rexp + 2'h1 : rexp;
    end
    always_ff @(posedge clk) begin
        tseq <= reset ? 2'h0 : next_tseq;
        rseq <= reset ? 2'h0 : next_rseq;
    end
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_tx_start;
        tx_strobe && (tx_phase_change || tx_retry);
    endsequence
    sequence s_tx_cont;
        tx_strobe && !tx_phase_change && !tx_retry;
    endsequence
    property p_tx_rsvd; tx_strobe |-> tx_db[9:8] == 2'h0; endproperty
    property p_rx_rsvd; rx_strobe |-> rx_db[9:8] == 2'h0; endproperty
    property p_tx_par; tx_strobe |-> tx_par == {~^tx_db[15:8], ~^tx_db[7:0]}; endproperty
    property p_rx_par; rx_strobe |-> rx_par == {~^rx_db[15:8], ~^rx_db[7:0]}; endproperty
    property p_tx_chk;
        tx_strobe |-> tx_db[15:10] == aipbch_ref_chk(tx_db[7:0], texp);
    endproperty
    property p_rx_chk;
        rx_strobe |-> rx_db[15:10] == aipbch_ref_chk(rx_db[7:0], rexp);
    endproperty
    property p_tx_restart;
        s_tx_start ##1 s_tx_cont |-> tx_db[15:10] == aipbch_ref_chk(tx_db[7:0], 2'h1);
    endproperty
    property p_tx_hold; !tx_strobe |-> $stable(tx_db) && $stable(tx_par); endproperty
    a_tx_rsvd: assert property (p_tx_rsvd) else $error("tx lines 8 9 driven");
    a_rx_rsvd: assert property (p_rx_rsvd) else $error("rx lines 8 9 driven");
    a_tx_par: assert property (p_tx_par) else $error("tx wide parity wrong");
    a_rx_par: assert property (p_rx_par) else $error("rx wide parity wrong");
    a_tx_chk: assert property (p_tx_chk) else $error("tx check byte wrong");
    a_rx_chk: assert property (p_rx_chk) else $error("rx check byte wrong");
    a_tx_restart: assert property (p_tx_restart) else $error("run restart wrong");
    a_tx_hold: assert property (p_tx_hold) else $error("tx word not held");
endmodule

/* dv/async_phase_bch_protection_bench.sv */
// Bench for both ends of the protected phase link
`timescale 1ns/100ps
`include "aipbch_ref.svh"
module async_phase_bch_protection_bench
    import aipbch_pkg::*;
;
    // Row: data, seq, mode (0 good 1 bad check 2 no upper 3 bad parity), nexus, iu/inv/err/en
    typedef struct packed {
        logic [7:0] data;
        logic [1:0] seq;
        logic [1:0] mode;
        logic [3:0] nx;
        logic       iu;
        logic       inv;
        logic       err;
        logic       en;
    } aipbch_row_t;
    aipbch_row_t rows [10] = '{20'hA_5031, 20'h3_C837, 20'h5_A236, 20'hC_3354, 20'hC_3058,
                               20'h7_E051, 20'h1_1157, 20'h2_2157, 20'h4_4157, 20'h8_8156};
    logic        clk = 1'h0;
    logic        reset = 1'h1;
    logic        clear_all = 1'h0;
    logic        iu_mode = 1'h0;
    logic        wide2 = 1'h1;
    logic [3:0]  nexus = 4'h0;
    logic        v1 = 1'h0, v2 = 1'h0, vp = 1'h0, spc = 1'h0, sr = 1'h0, bad_seen = 1'h0;
    logic [7:0]  sd = 8'h00;
    logic        p_valid, p_err, d1_valid, d1_inv, d1_err, d2_valid, d2_inv, d2_err;
    logic [7:0]  p_data, d1_data, d2_data;
    logic [15:0] d1_en, d2_en;
    logic [7:0]  pq [$];
    logic [7:0]  dq [$];
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles = 0;
    aipbch_link_if link1 ();
    aipbch_link_if link2 ();
    aipbch_dev u_aipbch_dev (.clk(clk), .reset(reset), .link(link1), .wide_ok(1'h1),
        .clear_all(clear_all), .iu_mode(1'h0), .nexus(4'h2), .send_valid(v1), .send_data(sd),
        .send_phase_change(spc), .send_retry(sr), .recv_valid(d1_valid), .recv_data(d1_data),
        .recv_invalid(d1_inv), .code_err(d1_err), .nexus_enabled(d1_en));
    aipbch_dev u_aipbch_dev_2 (.clk(clk), .reset(reset), .link(link2), .wide_ok(wide2),
        .clear_all(clear_all), .iu_mode(iu_mode), .nexus(nexus), .send_valid(v2), .send_data(sd),
        .send_phase_change(spc), .send_retry(sr), .recv_valid(d2_valid), .recv_data(d2_data),
        .recv_invalid(d2_inv), .code_err(d2_err), .nexus_enabled(d2_en));
    aipbch_peer u_aipbch_peer (.clk(clk), .reset(reset), .link(link1), .send_valid(vp),
        .send_data(sd), .send_phase_change(spc), .send_retry(sr), .recv_valid(p_valid),
        .recv_data(p_data), .recv_err(p_err));
    aipbch_chk u_aipbch_chk (.clk(clk), .reset(reset), .tx_db(link1.tx_db),
        .tx_par(link1.tx_par), .tx_strobe(link1.tx_strobe),
        .tx_phase_change(link1.tx_phase_change), .tx_retry(link1.tx_retry),
        .rx_db(link1.rx_db), .rx_par(link1.rx_par), .rx_strobe(link1.rx_strobe),
        .rx_phase_change(link1.rx_phase_change), .rx_retry(link1.rx_retry));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One word on a fresh run into the second device
    task automatic put_word(input aipbch_row_t r);
        logic [15:0] db;
        db = {aipbch_ref_chk(r.data, r.seq) ^ {6{r.mode == 2'h1}}, 2'h0, r.data};
        if (r.mode == 2'h2) db[15:8] = 8'h00;
        @(posedge clk);
        #10;
        nexus = r.nx;
        iu_mode = r.iu;
        link2.rx_db = db;
        link2.rx_par = {(r.mode == 2'h2) ? 1'h0 : ~^db[15:8], (~^db[7:0]) ^ (r.mode == 2'h3)};
        link2.rx_strobe = 1'h1;
        link2.rx_phase_change = 1'h1;
        @(posedge clk);
        #10;
        link2.rx_strobe = 1'h0;
        link2.rx_phase_change = 1'h0;
    endtask
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (p_valid === 1'h1) pq.push_back(p_data);
        if (d1_valid === 1'h1) dq.push_back(d1_data);
        if ((p_err | d1_inv | d1_err) !== 1'h0) bad_seen = 1'h1;
        if (cycles == 1000) begin
            mismatches++;
            wrap_up();
        end
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        link2.rx_db = 16'h0000;
        link2.rx_par = 2'h0;
        link2.rx_strobe = 1'h0;
        link2.rx_phase_change = 1'h0;
        link2.rx_retry = 1'h0;
        repeat (3) @(posedge clk);
        #10;
        reset = 1'h0;
        check(d1_en, 16'h0000);
        check(d2_en, 16'h0000);
        $display("test reset done");
        bad_seen = 1'h0;
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            #10;
            v1 = 1'h1;
            vp = 1'h1;
            sd = 8'h10 + 8'(i);
            spc = (i == 0);
            sr = (i == 5);
        end
        @(posedge clk);
        #10;
        v1 = 1'h0;
        vp = 1'h0;
        spc = 1'h0;
        sr = 1'h0;
        repeat (3) @(posedge clk);
        #10;
        check(16'(pq.size()), 16'h0007);
        check(16'(dq.size()), 16'h0007);
        for (int i = 0; i < 7; i++) begin
            check(pq[i], 8'h10 + 8'(i));
            check(dq[i], 8'h10 + 8'(i));
        end
        check(bad_seen, 1'h0);
        check(d1_en[2], 1'h1);
        $display("test traffic done");
        foreach (rows[k]) begin
            put_word(rows[k]);
            check(d2_valid, 1'h1);
            if (!rows[k].inv) check(d2_data, rows[k].data);
            check(d2_inv, rows[k].inv);
            check(d2_err, rows[k].err);
            @(posedge clk);
            #10;
            check(d2_en[rows[k].nx], rows[k].en);
        end
        $display("test rows done");
        put_word(rows[0]);
        put_word(rows[5]);
        @(posedge clk);
        #10;
        check(d2_en, 16'h0028);
        clear_all = 1'h1;
        @(posedge clk);
        #10;
        clear_all = 1'h0;
        @(posedge clk);
        #10;
        check(d2_en, 16'h0000);
        wide2 = 1'h0;
        v2 = 1'h1;
        spc = 1'h1;
        sd = 8'h96;
        @(posedge clk);
        #10;
        wide2 = 1'h1;
        check(link2.tx_db[15:8], 8'h00);
        @(posedge clk);
        #10;
        v2 = 1'h0;
        spc = 1'h0;
        check(link2.tx_db, {aipbch_ref_chk(8'h96, 2'h0), 2'h0, 8'h96});
        $display("test enables done");
        wrap_up();
    end
endmodule
